// *** core/dpo_consts.vh ***
// Constants for the DDR3 power-down and termination control block
`ifndef DPO_CONSTS_VH
`define DPO_CONSTS_VH

// Command codes {cs_n, ras_n, cas_n, we_n}
`define DPO_CMD_W        4
`define DPO_CMD_DESEL    4'h8
`define DPO_CMD_NOP      4'h7
`define DPO_CMD_ACT      4'h3
`define DPO_CMD_RD       4'h5
`define DPO_CMD_WR       4'h4
`define DPO_CMD_PRE      4'h2
`define DPO_CMD_REF      4'h1
`define DPO_CMD_MRS      4'h0
`define DPO_CMD_ZQ       4'h6

// Mode register field positions
`define DPO_MR0_PPD_BIT  12
`define DPO_MR1_RTT_B0   2
`define DPO_MR1_RTT_B1   6
`define DPO_MR1_RTT_B2   9
`define DPO_MR2_WR_B0    9
`define DPO_MR2_WR_B1    10
`define DPO_MR1_AL_LO    3
`define DPO_MR1_AL_HI    4
`define DPO_MR2_CWL_LO   3
`define DPO_MR2_CWL_HI   5
`define DPO_MR_BA_MR0    3'h0
`define DPO_MR_BA_MR1    3'h1
`define DPO_MR_BA_MR2    3'h2

// Latency constants in link clocks
`define DPO_ODT_LAT_SUB  5'h02
`define DPO_CWL_BASE     5'h05
`define DPO_TCPDED_NCK   4'h1
`define DPO_LAT_W        5
`define DPO_PIPE_LEN     32
`define DPO_NUM_BANKS    8

`endif

// *** core/dpo_ctrl.v ***
// DDR3 device power-down state keeping and synchronous termination control
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "dpo_consts.vh"

module dpo_ctrl #(
	parameter RD_LAT      = 11,	// Read latency in link clocks
	parameter BURST_LEN   = 4	// Link clocks the data bus is driven
) (
	input  wire        CLK_IN,
	input  wire        RST_N_IN,
	input  wire        CK_IN,
	input  wire        CKE_IN,
	input  wire        ODT_IN,
	input  wire        RESET_N_IN,
	input  wire        CS_N_IN,
	input  wire        RAS_N_IN,
	input  wire        CAS_N_IN,
	input  wire        WE_N_IN,
	input  wire [2:0]  BA_IN,
	input  wire [15:0] ADDR_IN,
	input  wire        DLL_LOCKED_IN,
	input  wire        SELF_REFRESH_IN,
	output reg         POWER_DOWN_OUT,
	output reg         ACTIVE_PD_OUT,
	output reg         PRECHARGE_PD_OUT,
	output reg         DLL_ON_OUT,
	output reg         BUF_EN_OUT,
	output reg         CMD_RX_EN_OUT,
	output reg         IN_RESET_OUT,
	output reg         TERM_ON_OUT,
	output reg  [4:0]  TERM_SEL_OUT,
	output reg         DQ_DRIVE_OUT
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam NIN = 12;
	wire [NIN-1:0] raw_in = {CK_IN, CKE_IN, ODT_IN, RESET_N_IN, CS_N_IN,
		RAS_N_IN, CAS_N_IN, WE_N_IN, BA_IN, SELF_REFRESH_IN};
	reg  [NIN-1:0] s1_r, s2_r, s3_r, stab_r;
	reg  [15:0]    a1_r, a2_r, a3_r, astab_r;

	// Three stages; value accepted when the last two agree
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			s1_r    <= 12'h0F0;
			s2_r    <= 12'h0F0;
			s3_r    <= 12'h0F0;
			stab_r  <= 12'h0F0;
			a1_r    <= 16'h0000;
			a2_r    <= 16'h0000;
			a3_r    <= 16'h0000;
			astab_r <= 16'h0000;
		end else begin
			s1_r   <= raw_in;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			// Hold the last agreed value while the stages disagree
			stab_r <= (stab_r & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));
			a1_r   <= ADDR_IN;
			a2_r   <= a1_r;
			a3_r   <= a2_r;
			astab_r <= (astab_r & (a2_r ^ a3_r)) | (a2_r & ~(a2_r ^ a3_r));
		end
	end

	wire       ck_s    = stab_r[11];
	wire       cke_s   = stab_r[10];
	wire       odt_s   = stab_r[9];
	wire       rstp_s  = stab_r[8];
	wire [3:0] cmd_s   = stab_r[7:4];
	wire [2:0] ba_s    = stab_r[3:1];
	wire       sr_s    = stab_r[0];

	// ------------------------------------------------------------
	// Link clock edge finder
	// ------------------------------------------------------------
	reg  ck_d_r;
	wire ck_rise = ck_s & ~ck_d_r;

	always @(posedge CLK_IN) begin
		if (!RST_N_IN)
			ck_d_r <= 1'b0;
		else
			ck_d_r <= ck_s;
	end

	// Command decode with chip select
	function is_nop;
		input [3:0] c;
		begin
			is_nop = c[3] | (c == `DPO_CMD_NOP);
		end
	endfunction

	function is_cmd;
		input [3:0] c;
		input [3:0] k;
		begin
			is_cmd = ~c[3] & (c[2:0] == k[2:0]);
		end
	endfunction

	// ------------------------------------------------------------
	// Mode registers, bank tracking, power-down state
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_PD   = 3'b010;
	localparam ST_RST  = 3'b100;

	reg  [2:0]  st_r, st_nxt;
	reg         ppd_keep_dll_r;
	reg  [4:0]  rtt_bits_r;
	reg  [1:0]  al_code_r;
	reg  [2:0]  cwl_code_r;
	reg  [7:0]  bank_open_r;
	reg         cke_prev_r;
	reg  [3:0]  cpded_cnt_r;

	wire cmd_ok = is_nop(cmd_s);
	wire enter  = ck_rise & cke_prev_r & ~cke_s & cmd_ok;
	wire leave  = ck_rise & ~cke_prev_r & cke_s & cmd_ok;

	// State machine next state
	always @* begin
		st_nxt = st_r;
		case (st_r)
		ST_IDLE: begin
			if (enter)
				st_nxt = ST_PD;
		end
		ST_PD: begin
			if (leave)
				st_nxt = ST_IDLE;
		end
		ST_RST: begin
			st_nxt = ST_IDLE;
		end
		default: st_nxt = ST_IDLE;
		endcase
		if (!rstp_s)
			st_nxt = ST_RST;
	end

	// Additive latency from MR1 code: 1 gives CWL, 2 gives CWL-1, 0 and 3 give 0
	function [4:0] add_lat;
		input [1:0] code;
		input [4:0] cwl;
		begin
			case (code)
			2'h1:    add_lat = cwl;
			2'h2:    add_lat = cwl - 5'h01;
			default: add_lat = 5'h00;
			endcase
		end
	endfunction

	wire [4:0] cwl_val = `DPO_CWL_BASE + {2'h0, cwl_code_r};
	wire [4:0] al_val  = add_lat(al_code_r, cwl_val);
	wire [4:0] odt_lat = cwl_val + al_val - `DPO_ODT_LAT_SUB;

	// Sequential state, mode registers and bank bookkeeping
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			st_r             <= ST_RST;
			ppd_keep_dll_r   <= 1'b0;
			rtt_bits_r       <= 5'h00;
			al_code_r        <= 2'h0;
			cwl_code_r       <= 3'h0;
			bank_open_r      <= 8'h00;
			cke_prev_r       <= 1'b0;
			cpded_cnt_r      <= 4'h0;
		end else begin
			st_r <= st_nxt;
			if (ck_rise)
				cke_prev_r <= cke_s;
			if (st_nxt == ST_RST) begin
				bank_open_r <= 8'h00;
				rtt_bits_r  <= 5'h00;
			end else if (ck_rise && cke_s && st_r == ST_IDLE) begin
				if (is_cmd(cmd_s, `DPO_CMD_MRS)) begin
					if (ba_s == `DPO_MR_BA_MR0)
						ppd_keep_dll_r <= astab_r[`DPO_MR0_PPD_BIT];
					if (ba_s == `DPO_MR_BA_MR1) begin
						rtt_bits_r[2:0] <= {astab_r[`DPO_MR1_RTT_B2],
							astab_r[`DPO_MR1_RTT_B1],
							astab_r[`DPO_MR1_RTT_B0]};
						al_code_r <= astab_r[`DPO_MR1_AL_HI:`DPO_MR1_AL_LO];
					end
					if (ba_s == `DPO_MR_BA_MR2) begin
						rtt_bits_r[4:3] <= {astab_r[`DPO_MR2_WR_B1],
							astab_r[`DPO_MR2_WR_B0]};
						cwl_code_r <= astab_r[`DPO_MR2_CWL_HI:`DPO_MR2_CWL_LO];
					end
				end
				if (is_cmd(cmd_s, `DPO_CMD_ACT))
					bank_open_r[ba_s] <= 1'b1;
				if (is_cmd(cmd_s, `DPO_CMD_PRE))
					bank_open_r <= astab_r[10] ? 8'h00 :
						(bank_open_r & ~(8'h01 << ba_s));
			end
			// Receivers stay on tCPDED after entry
			if (enter)
				cpded_cnt_r <= `DPO_TCPDED_NCK;
			else if (ck_rise && cpded_cnt_r != 4'h0)
				cpded_cnt_r <= cpded_cnt_r - 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Power-down outputs
	// ------------------------------------------------------------
	wire in_pd   = (st_r == ST_PD);
	wire any_open = |bank_open_r;
	wire dll_on  = ~in_pd | any_open | ppd_keep_dll_r;

	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			POWER_DOWN_OUT   <= 1'b0;
			ACTIVE_PD_OUT    <= 1'b0;
			PRECHARGE_PD_OUT <= 1'b0;
			DLL_ON_OUT       <= 1'b0;
			BUF_EN_OUT       <= 1'b0;
			CMD_RX_EN_OUT    <= 1'b0;
			IN_RESET_OUT     <= 1'b1;
		end else begin
			POWER_DOWN_OUT   <= in_pd;
			// Mode set by bank state at entry; banks are not updated in power-down
			ACTIVE_PD_OUT    <= in_pd & any_open;
			PRECHARGE_PD_OUT <= in_pd & ~any_open;
			DLL_ON_OUT       <= dll_on & (st_r != ST_RST);
			BUF_EN_OUT       <= ~in_pd & (st_r != ST_RST);
			CMD_RX_EN_OUT    <= (~in_pd | (cpded_cnt_r != 4'h0)) &
				(st_r != ST_RST);
			IN_RESET_OUT     <= (st_r == ST_RST);
		end
	end

	// ------------------------------------------------------------
	// Termination: ODT pipeline, read drive window
	// ------------------------------------------------------------
	reg [`DPO_PIPE_LEN-1:0] odt_pipe_r;
	reg [`DPO_PIPE_LEN-1:0] rd_pipe_r;
	reg [3:0]               drv_cnt_r;

	wire term_en   = |rtt_bits_r;
	wire sync_mode = dll_on & DLL_LOCKED_IN;
	// Tap n holds the ODT level sampled n link clocks ago
	wire odt_late  = odt_pipe_r[odt_lat];
	wire rd_cmd    = ck_rise & cke_s & (st_r == ST_IDLE) &
		is_cmd(cmd_s, `DPO_CMD_RD);
	wire [4:0] rl  = RD_LAT[4:0];
	wire rd_start  = rd_pipe_r[rl - 5'h01];

	// Shift ODT and reads one slot per link clock
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			odt_pipe_r <= 32'h00000000;
			rd_pipe_r  <= 32'h00000000;
			drv_cnt_r  <= 4'h0;
		end else if (ck_rise) begin
			// AL folded into the pipeline tap
			odt_pipe_r <= {odt_pipe_r[`DPO_PIPE_LEN-2:0], odt_s};
			rd_pipe_r  <= {rd_pipe_r[`DPO_PIPE_LEN-2:0], rd_cmd};
			if (rd_start)
				drv_cnt_r <= BURST_LEN[3:0];
			else if (drv_cnt_r != 4'h0)
				drv_cnt_r <= drv_cnt_r - 4'h1;
		end
	end

	// Termination output, off while driving the bus
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			TERM_ON_OUT  <= 1'b0;
			TERM_SEL_OUT <= 5'h00;
			DQ_DRIVE_OUT <= 1'b0;
		end else begin
			DQ_DRIVE_OUT <= (drv_cnt_r != 4'h0);
			TERM_SEL_OUT <= rtt_bits_r;
			TERM_ON_OUT  <= term_en & ~sr_s & sync_mode &
				(st_r != ST_RST) & odt_late &
				(drv_cnt_r == 4'h0);
		end
	end

endmodule // dpo_ctrl

// *** verification/dpo_ctrl_monitor.sv ***
// Port checker for power-down and termination behaviour
`timescale 1ns/1ps
module dpo_ctrl_monitor (
	input wire		CLK_IN,
	input wire		RST_N_IN,
	input wire		CKE_IN,
	input wire		RESET_N_IN,
	input wire		POWER_DOWN_OUT,
	input wire		ACTIVE_PD_OUT,
	input wire		DLL_ON_OUT,
	input wire		BUF_EN_OUT,
	input wire		CMD_RX_EN_OUT,
	input wire		IN_RESET_OUT,
	input wire		TERM_ON_OUT,
	input wire [4:0]	TERM_SEL_OUT,
	input wire		DQ_DRIVE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Steps of entry: state rises, receivers drop one CK later
	sequence pd_entry;
		$rose(POWER_DOWN_OUT);
	endsequence
	sequence rx_off_late;
		CMD_RX_EN_OUT ##[10:30] !CMD_RX_EN_OUT;
	endsequence
	sequence pin_low;
		!RESET_N_IN [*8];
	endsequence
	chk_pd_cke_low: assert property (pd_entry |-> !$past(CKE_IN, 6))
		else $error("entry without CKE low");
	chk_rx_off_late: assert property (pd_entry |-> rx_off_late)
		else $error("receiver shut-off wrong");
	chk_pd_buf_off: assert property (POWER_DOWN_OUT |-> !BUF_EN_OUT)
		else $error("buffers on in power-down");
	chk_apd_dll_on: assert property (ACTIVE_PD_OUT |-> DLL_ON_OUT)
		else $error("DLL off in active power-down");
	chk_reset_pin: assert property (pin_low |->
		##[0:2] (IN_RESET_OUT && !POWER_DOWN_OUT))
		else $error("reset pin ignored");
	chk_sel_gate: assert property (
		(TERM_SEL_OUT == 5'h00) [*2] |-> !TERM_ON_OUT)
		else $error("termination on while disabled");
	chk_dll_term: assert property (!DLL_ON_OUT |-> !TERM_ON_OUT)
		else $error("termination on with DLL off");
	chk_drive_term: assert property (DQ_DRIVE_OUT |-> !TERM_ON_OUT)
		else $error("termination on while driving");
endmodule // dpo_ctrl_monitor

bind dpo_ctrl dpo_ctrl_monitor u_dpo_ctrl_monitor (.*);

// *** verification/dpo_host_model.sv ***
// Controller model: free-running CK and one command per CK period
`timescale 1ns/1ps
`include "dpo_consts.vh"
module dpo_host (
	input wire		clk_in,
	output logic		ck_out,
	output logic		cke_out,
	output logic		odt_out,
	output logic		reset_n_out,
	output logic [3:0]	cmd_out,
	output logic [15:0]	addr_out,
	output logic [2:0]	ba_out
);
	logic [4:0]	cnt_r = 5'h00;
	// Pins start idle: NOP, CKE high, reset pin released
	initial begin
		ck_out = 1'b1;
		cke_out = 1'b1;
		odt_out = 1'b0;
		reset_n_out = 1'b1;
		cmd_out = `DPO_CMD_NOP;
		addr_out = 16'h0000;
		ba_out = 3'h0;
	end
	// CK of 20 system clocks, kept running in power-down
	always @(posedge clk_in) begin
		cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
		ck_out <= (cnt_r == 5'h13) || (cnt_r < 5'h09);
	end
	// Drive after CK falls, hold across the next rising edge
	task automatic issue(input logic [3:0] c, input logic k,
		input logic o, input logic [2:0] b, input logic [15:0] a);
		do @(posedge clk_in); while (cnt_r != 5'h0A);
		cmd_out <= c;
		cke_out <= k;
		odt_out <= o;
		ba_out <= b;
		addr_out <= (c == `DPO_CMD_NOP) ? ~addr_out : a; // Unused bus toggles
		do @(posedge clk_in); while (cnt_r != 5'h09);
	endtask
	// Reset pin changed between commands
	task automatic pin_reset(input logic v);
		@(posedge clk_in);
		reset_n_out <= v;
	endtask
endmodule // dpo_host

// *** verification/dpo_ctrl_tb.sv ***
// Directed bench for power-down and termination control
`timescale 1ns/1ps
`include "dpo_consts.vh"
module dpo_ctrl_tb;
	logic		clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		lock = 1'b1;
	logic		sref = 1'b0;
	logic		ck, cke, odt, prst_n, pd, apd, ppd, dll, buf_en;
	logic		rx, in_rst, term, dq;
	logic [3:0]	cmd;
	logic [2:0]	ba;
	logic [15:0]	adr;
	logic [4:0]	sel;
	int		num_errors = 0;
	int		n_checks = 0;
	// Termination latency with CWL code 0 and no additive latency
	localparam int	odt_lat_base = `DPO_CWL_BASE - `DPO_ODT_LAT_SUB;
	wire [7:0]	stat = {pd, apd, ppd, dll, buf_en, rx, in_rst, dq};

	// 250 MHz system clock
	always #2 clk = ~clk;
	dpo_host u_dpo_host (.clk_in(clk), .ck_out(ck), .cke_out(cke),
		.odt_out(odt), .reset_n_out(prst_n), .cmd_out(cmd),
		.addr_out(adr), .ba_out(ba));
	dpo_ctrl #(.RD_LAT(3), .BURST_LEN(2)) u_dpo_ctrl (.CLK_IN(clk),
		.RST_N_IN(rst_n), .CK_IN(ck), .CKE_IN(cke), .ODT_IN(odt),
		.RESET_N_IN(prst_n), .CS_N_IN(cmd[3]), .RAS_N_IN(cmd[2]),
		.CAS_N_IN(cmd[1]), .WE_N_IN(cmd[0]), .BA_IN(ba), .ADDR_IN(adr),
		.DLL_LOCKED_IN(lock), .SELF_REFRESH_IN(sref),
		.POWER_DOWN_OUT(pd), .ACTIVE_PD_OUT(apd),
		.PRECHARGE_PD_OUT(ppd), .DLL_ON_OUT(dll), .BUF_EN_OUT(buf_en),
		.CMD_RX_EN_OUT(rx), .IN_RESET_OUT(in_rst), .TERM_ON_OUT(term),
		.TERM_SEL_OUT(sel), .DQ_DRIVE_OUT(dq));
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic nop(input logic k, input logic o);
		u_dpo_host.issue(`DPO_CMD_NOP, k, o, 3'h0, 16'h0000);
	endtask
	task automatic go(input logic [3:0] c, input logic [15:0] a);
		u_dpo_host.issue(c, 1'b1, 1'b0, 3'h0, a);
	endtask
	task automatic mrs(input logic [2:0] b, input logic [15:0] a,
		input logic [4:0] e);
		u_dpo_host.issue(`DPO_CMD_MRS, 1'b1, 1'b0, b, a);
		chk("term_sel", {3'h0, e}, {3'h0, sel});
	endtask
	// Status after n more CK edges, ODT low
	task automatic step(input int n, input logic k, input logic [7:0] e);
		repeat (n) nop(k, 1'b0);
		chk("status", e, stat);
	endtask
	// Termination follows ODT by n = CWL+AL-2 CK edges
	task automatic odt_walk(input logic v, input int n);
		repeat (n) nop(1'b1, v);
		chk("term_early", {7'h00, ~v}, {7'h00, term});
		nop(1'b1, v);
		chk("term", {7'h00, v}, {7'h00, term});
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Ceiling well above the ~1500 cycles the tests need
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		chk("status", 8'h1C, stat);
		$display("test reset done");
		mrs(3'h1, 16'h0040, 5'h02);
		mrs(3'h2, 16'h0600, 5'h1A);
		mrs(3'h2, 16'h0000, 5'h02);
		mrs(3'h1, 16'h0204, 5'h05);
		mrs(3'h0, 16'h1000, 5'h05);
		odt_walk(1'b1, odt_lat_base);
		odt_walk(1'b0, odt_lat_base);
		// CWL code 1 stretches the termination latency by one CK
		mrs(3'h2, 16'h0008, 5'h05);
		odt_walk(1'b1, odt_lat_base + 1);
		// Self refresh and a lost lock both force termination off
		sref <= 1'b1;
		nop(1'b1, 1'b1);
		chk("term_sref", 8'h00, {7'h00, term});
		sref <= 1'b0;
		lock <= 1'b0;
		nop(1'b1, 1'b1);
		chk("term_unlock", 8'h00, {7'h00, term});
		lock <= 1'b1;
		nop(1'b1, 1'b1);
		chk("term_relock", 8'h01, {7'h00, term});
		odt_walk(1'b0, odt_lat_base + 1);
		mrs(3'h2, 16'h0000, 5'h05);
		mrs(3'h1, 16'h0000, 5'h00);
		repeat (4) nop(1'b1, 1'b1);
		chk("term_off", 8'h00, {7'h00, term});
		repeat (4) nop(1'b1, 1'b0);
		mrs(3'h1, 16'h0004, 5'h01);
		$display("test termination done");
		go(`DPO_CMD_ACT, 16'h0000);
		go(`DPO_CMD_RD, 16'h0000);
		step(2, 1'b1, 8'h1C);
		step(1, 1'b1, 8'h1D);
		step(2, 1'b1, 8'h1C);
		step(1, 1'b0, 8'hD4);
		step(2, 1'b0, 8'hD0);
		step(1, 1'b1, 8'h1C);
		step(3, 1'b1, 8'h1C);
		go(`DPO_CMD_PRE, 16'h0400);
		for (int i = 0; i < 2; i++) begin
			mrs(3'h0, {3'h0, i[0], 12'h000}, 5'h01);
			step(1, 1'b0, {3'h5, i[0], 4'h4});
			step(2, 1'b0, {3'h5, i[0], 4'h0});
			if (i == 0) step(6, 1'b1, 8'h1C);
		end
		u_dpo_host.pin_reset(1'b0);
		step(2, 1'b0, 8'h02);
		u_dpo_host.pin_reset(1'b1);
		step(2, 1'b1, 8'h1C);
		chk("term_sel", 8'h00, {3'h0, sel});
		$display("test power-down done");
		complete_run();
	end
endmodule // dpo_ctrl_tb
